/* logic/pscc_pkg.sv */
// Package for the power stage configuration command bank.
// Assumes a command-code register port driven by a PMBus front end.
package pscc_pkg;
	// Command codes
	localparam logic [7:0] CMD_INDUCTANCE    = 8'hD6;
	localparam logic [7:0] CMD_FAST_TRANS    = 8'hD7;
	localparam logic [7:0] CMD_VFAULT        = 8'hD8;
	localparam logic [7:0] CMD_XT_SCALE      = 8'hD9;
	localparam logic [7:0] CMD_XT_OFFSET     = 8'hDA;
	localparam logic [7:0] CMD_SENSE_TC      = 8'hDC;
	localparam logic [7:0] CMD_NOVL_TIMES    = 8'hDD;
	localparam logic [7:0] CMD_NOVL_MODE     = 8'hDE;
	localparam logic [7:0] CMD_RAIL_ORDER    = 8'hE0;
	localparam logic [7:0] CMD_FOLLOW        = 8'hE1;
	// Reset values
	localparam logic [15:0] RST_INDUCTANCE   = 16'hB200;
	localparam logic [31:0] RST_FAST_TRANS   = 32'h00000000;
	localparam logic [7:0]  RST_VFAULT       = 8'h00;
	localparam logic [15:0] RST_XT_SCALE     = 16'hBA00;
	localparam logic [15:0] RST_XT_OFFSET    = 16'h8000;
	localparam logic [7:0]  RST_SENSE_TC     = 8'h28;
	localparam logic [15:0] RST_NOVL_TIMES   = 16'h1414;
	localparam logic [15:0] RST_NOVL_MODE    = 16'h8686;
	localparam logic [15:0] RST_RAIL_ORDER   = 16'h0000;
	localparam logic [7:0]  RST_FOLLOW       = 8'h00;
	// Writable masks; reserved bits read zero
	localparam logic [7:0]  MASK_VFAULT      = 8'h8F;
	localparam logic [15:0] MASK_RAIL_ORDER  = 16'h9F9F;
	localparam logic [7:0]  MASK_FOLLOW      = 8'h87;
	// Field positions
	localparam int VF_LOWSIDE_BIT = 7;
	localparam int VF_COUNT_HI    = 3;
	localparam int TC_SRC_BIT     = 7;
	localparam int NM_HL_FRZ_BIT  = 15;
	localparam int NM_LH_FRZ_BIT  = 7;
	localparam int RO_EN_BIT      = 7;
	localparam int FW_EN_BIT      = 7;
	localparam int FW_HALF_BIT    = 2;
	localparam int FW_LIMIT_BIT   = 1;
	localparam int FW_DOWN_BIT    = 0;
	// Non-overlap minimum field step, in ns
	localparam int NOVL_MIN_STEP_NS = 2;
	// Blanking table in sixty-fourths of the switching period
	localparam logic [7:0] BLANK_TABLE [16] = '{
		8'h01, 8'h02, 8'h03, 8'h05, 8'h09, 8'h11, 8'h21, 8'h31,
		8'h41, 8'h51, 8'h61, 8'h81, 8'hA1, 8'hB1, 8'hC1, 8'hE1};
	// Sequencing phases
	typedef enum logic [1:0] {PSCC_OFF, PSCC_WAIT_UP, PSCC_ON} pscc_seq_t;
endpackage

/* logic/pscc_top.sv */
// Configuration command bank of a point-of-load controller.
// Assumes a command front end giving a code, data, write and read strobes.
// Function
// - Coefficient bytes move lowest byte first.
// - Load inner threshold is 0.5% times (code+1).
// - Release inner threshold is 0.5% times (code+1).
// - Top two bits multiply inner to outer thresholds.
// - Four correction times in sixty-fourth periods.
// - Two fields select load and release blanking.
// - Blanking codes map to fixed unit table.
// - Over-voltage shutdown may turn low side on.
// - Fault after N+1 consecutive limit violations.
// - Temperature reading is value plus offset; scale held at one.
// - Bit seven picks temperature source.
// - Sense resistance gain times temperature correction.
// - Non-overlap bytes: signed high-low, low-high.
// - Frozen non-overlap clamped between min and max.
// - Frozen value keeps last adaptive value.
// - Mode bits and adaptive minimum fields.
// - Enable waits for predecessor power-good.
// - Disable after successor power-down event.
// - Sequence register holds ids and enables.
// - Tracking enable and half ratio select.
// - Tracking limit and downward tracking select.
// - Downward tracking allowed before power-good.
`timescale 1ns/1ps
module pscc_top
	import pscc_pkg::*;
#(
	parameter int BYTE_W = 8
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	// Command register port
	input  wire logic [7:0]         cmd_code,
	input  wire logic               cmd_write,
	input  wire logic               cmd_read,
	input  wire logic [31:0]        cmd_wdata,
	output logic      [31:0]        cmd_rdata,
	output logic                    cmd_valid,
	// Coefficient byte stream
	input  wire logic               coef_byte_valid,
	input  wire logic [BYTE_W-1:0]  coef_byte,
	input  wire logic               coef_start,
	output logic      [3:0]         coef_index,
	// Fast transient results
	output logic      [3:0]         load_inner_pct_half,
	output logic      [3:0]         release_inner_pct_half,
	output logic      [1:0]         outer_multiplier,
	output logic      [3:0]         load_outer_corr_time,
	output logic      [3:0]         load_inner_corr_time,
	output logic      [3:0]         release_outer_corr_time,
	output logic      [3:0]         release_inner_corr_time,
	output logic      [7:0]         load_blank_units,
	output logic      [7:0]         release_blank_units,
	// Voltage fault
	input  wire logic               ov_violation,
	input  wire logic               uv_violation,
	input  wire logic               sample_strobe,
	output logic                    ov_fault,
	output logic                    uv_fault,
	output logic                    lowside_on_ov,
	// Temperature
	input  wire logic [15:0]        ext_temp_measured,
	output logic      [15:0]        ext_temp_report,
	output logic                    temp_src_external,
	output logic      [6:0]         temp_coeff_factor,
	// Non-overlap
	input  wire logic [7:0]         adaptive_hl_ns,
	input  wire logic [7:0]         adaptive_lh_ns,
	input  wire logic [7:0]         novl_max_hl_ns,
	input  wire logic [7:0]         novl_max_lh_ns,
	output logic      [7:0]         novl_hl_ns,
	output logic      [7:0]         novl_lh_ns,
	// Sequencing over the inter-rail bus
	input  wire logic               enable_request,
	input  wire logic               bus_event_valid,
	input  wire logic               bus_event_pgood,
	input  wire logic [4:0]         bus_event_rail,
	output logic                    output_enable,
	// Tracking
	output logic                    track_enable,
	output logic                    track_half,
	output logic                    track_limit_input,
	output logic                    track_down_allowed,
	input  wire logic               power_good_flag
);
	// All registered state
	typedef struct packed {
		logic [15:0] inductance;
		logic [31:0] fast;
		logic [7:0]  vfault;
		logic [15:0] xt_scale;
		logic [15:0] xt_offset;
		logic [7:0]  sense_tc;
		logic [15:0] novl_times;
		logic [15:0] novl_mode;
		logic [15:0] rail_order;
		logic [7:0]  follow;
		logic [3:0]  ov_count;
		logic [3:0]  uv_count;
		logic        ov_fault;
		logic        uv_fault;
		logic [7:0]  hl_used;
		logic [7:0]  lh_used;
		logic [15:0] temp_report;
		logic [3:0]  coef_idx;
		logic [31:0] rdata;
		logic        rvalid;
		logic [3:0]  load_pct;     // Load inner level, half percent steps
		logic [3:0]  rel_pct;      // Release inner level, half percent steps
		logic [7:0]  load_blank;   // Load blanking in sixty-fourth periods
		logic [7:0]  rel_blank;    // Release blanking in sixty-fourth periods
		logic        lowside;      // Low side held on after OV shutdown
		logic        down_ok;      // Downward tracking allowed
		pscc_seq_t   seq;
	} pscc_state_t;

	pscc_state_t st_reg;   // Current state
	pscc_state_t st_next;  // Next state

	// Signed clamp of a value between lower and upper limits
	function automatic logic [7:0] clamp_s(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		logic [7:0] r;
		r = v;
		if ($signed(v) < $signed(lo)) begin
			r = lo;
		end
		if ($signed(r) > $signed(hi)) begin
			r = hi;
		end
		return r;
	endfunction

	// Read mux for one command code
	function automatic logic [31:0] read_mux(input pscc_state_t s, input logic [7:0] c);
		logic [31:0] r;
		r = 32'h00000000;
		case (c)
			CMD_INDUCTANCE: r = {16'h0000, s.inductance};
			CMD_FAST_TRANS: r = s.fast;
			CMD_VFAULT:     r = {24'h000000, s.vfault};
			CMD_XT_SCALE:   r = {16'h0000, s.xt_scale};
			CMD_XT_OFFSET:  r = {16'h0000, s.xt_offset};
			CMD_SENSE_TC:   r = {24'h000000, s.sense_tc};
			CMD_NOVL_TIMES: r = {16'h0000, s.novl_times};
			CMD_NOVL_MODE:  r = {16'h0000, s.novl_mode};
			CMD_RAIL_ORDER: r = {16'h0000, s.rail_order};
			CMD_FOLLOW:     r = {24'h000000, s.follow};
			default:        r = 32'h00000000;
		endcase
		return r;
	endfunction

	// Combinational next-state
	always_comb begin
		logic [7:0] min_hl;
		logic [7:0] min_lh;
		logic       pred_on;
		logic       succ_on;
		min_hl = 8'h00;
		min_lh = 8'h00;
		pred_on = 1'b0;
		succ_on = 1'b0;
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		// Register writes with reserved bits masked
		if (cmd_write) begin
			case (cmd_code)
				CMD_INDUCTANCE: st_next.inductance = cmd_wdata[15:0];
				CMD_FAST_TRANS: st_next.fast = cmd_wdata;
				CMD_VFAULT:     st_next.vfault = cmd_wdata[7:0] & MASK_VFAULT;
				CMD_XT_SCALE:   st_next.xt_scale = cmd_wdata[15:0];
				CMD_XT_OFFSET:  st_next.xt_offset = cmd_wdata[15:0];
				CMD_SENSE_TC:   st_next.sense_tc = cmd_wdata[7:0];
				CMD_NOVL_TIMES: st_next.novl_times = cmd_wdata[15:0];
				CMD_NOVL_MODE:  st_next.novl_mode = cmd_wdata[15:0];
				CMD_RAIL_ORDER: st_next.rail_order = cmd_wdata[15:0] & MASK_RAIL_ORDER;
				CMD_FOLLOW:     st_next.follow = cmd_wdata[7:0] & MASK_FOLLOW;
				default:        st_next.rvalid = 1'b0;
			endcase
		end
		// Register reads answer one cycle later
		if (cmd_read) begin
			st_next.rdata = read_mux(st_reg, cmd_code);
			st_next.rvalid = 1'b1;
		end
		// Coefficient byte counter, byte 0 first
		if (coef_start) begin
			st_next.coef_idx = 4'h0;
		end else if (coef_byte_valid && st_reg.coef_idx != 4'h8) begin
			st_next.coef_idx = st_reg.coef_idx + 4'h1;
		end
		// Consecutive violation filter, N+1 needed
		if (sample_strobe) begin
			if (ov_violation) begin
				if (st_reg.ov_count == st_reg.vfault[VF_COUNT_HI:0]) begin
					st_next.ov_fault = 1'b1;
				end else begin
					st_next.ov_count = st_reg.ov_count + 4'h1;
				end
			end else begin
				st_next.ov_count = 4'h0;
			end
			if (uv_violation) begin
				if (st_reg.uv_count == st_reg.vfault[VF_COUNT_HI:0]) begin
					st_next.uv_fault = 1'b1;
				end else begin
					st_next.uv_count = st_reg.uv_count + 4'h1;
				end
			end else begin
				st_next.uv_count = 4'h0;
			end
		end
		// Temperature report: scale held at one, so value plus offset
		st_next.temp_report = ext_temp_measured + st_reg.xt_offset;
		// Non-overlap: adaptive follows loop, frozen holds last or written
		min_hl = {st_reg.novl_mode[14:8], 1'b0};
		min_lh = {st_reg.novl_mode[6:0], 1'b0};
		if (!st_reg.novl_mode[NM_HL_FRZ_BIT]) begin
			st_next.hl_used = clamp_s(adaptive_hl_ns, min_hl, novl_max_hl_ns);
		end else if (cmd_write && cmd_code == CMD_NOVL_TIMES) begin
			st_next.hl_used = clamp_s(cmd_wdata[15:8], min_hl, novl_max_hl_ns);
		end
		if (!st_reg.novl_mode[NM_LH_FRZ_BIT]) begin
			st_next.lh_used = clamp_s(adaptive_lh_ns, min_lh, novl_max_lh_ns);
		end else if (cmd_write && cmd_code == CMD_NOVL_TIMES) begin
			st_next.lh_used = clamp_s(cmd_wdata[7:0], min_lh, novl_max_lh_ns);
		end
		// Entering frozen keeps hl_used/lh_used as they stand
		// Sequencing against predecessor and successor rails
		pred_on = st_reg.rail_order[8+RO_EN_BIT];
		succ_on = st_reg.rail_order[RO_EN_BIT];
		case (st_reg.seq)
			PSCC_OFF: begin
				if (enable_request) begin
					st_next.seq = pred_on ? PSCC_WAIT_UP : PSCC_ON;
				end
			end
			PSCC_WAIT_UP: begin
				if (!enable_request) begin
					st_next.seq = PSCC_OFF;
				end else if (bus_event_valid && bus_event_pgood
					&& bus_event_rail == st_reg.rail_order[12:8]) begin
					st_next.seq = PSCC_ON;
				end
			end
			PSCC_ON: begin
				if (!enable_request) begin
					st_next.seq = PSCC_OFF;
				end else if (succ_on && bus_event_valid && !bus_event_pgood
					&& bus_event_rail == st_reg.rail_order[4:0]) begin
					st_next.seq = PSCC_OFF;
				end
			end
			default: st_next.seq = PSCC_OFF;
		endcase
		// Decodes follow the next register values, so they change
		// on the same edge as the write that feeds them
		st_next.load_pct = {1'b0, st_next.fast[29:27]} + 4'h1;
		st_next.rel_pct = {1'b0, st_next.fast[26:24]} + 4'h1;
		st_next.load_blank = BLANK_TABLE[st_next.fast[7:4]];
		st_next.rel_blank = BLANK_TABLE[st_next.fast[3:0]];
		// Low side on only for an OV shutdown with the bit set
		st_next.lowside = st_next.ov_fault & st_next.vfault[VF_LOWSIDE_BIT];
		// Downward tracking opens with its bit or once power is good
		st_next.down_ok = st_next.follow[FW_DOWN_BIT] | power_good_flag;
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= '{
				inductance:  RST_INDUCTANCE,
				fast:        RST_FAST_TRANS,
				vfault:      RST_VFAULT,
				xt_scale:    RST_XT_SCALE,
				xt_offset:   RST_XT_OFFSET,
				sense_tc:    RST_SENSE_TC,
				novl_times:  RST_NOVL_TIMES,
				novl_mode:   RST_NOVL_MODE,
				rail_order:  RST_RAIL_ORDER,
				follow:      RST_FOLLOW,
				ov_count:    4'h0,
				uv_count:    4'h0,
				ov_fault:    1'b0,
				uv_fault:    1'b0,
				hl_used:     RST_NOVL_TIMES[15:8],
				lh_used:     RST_NOVL_TIMES[7:0],
				temp_report: 16'h0000,
				coef_idx:    4'h0,
				rdata:       32'h00000000,
				rvalid:      1'b0,
				load_pct:    {1'b0, RST_FAST_TRANS[29:27]} + 4'h1,
				rel_pct:     {1'b0, RST_FAST_TRANS[26:24]} + 4'h1,
				load_blank:  BLANK_TABLE[RST_FAST_TRANS[7:4]],
				rel_blank:   BLANK_TABLE[RST_FAST_TRANS[3:0]],
				lowside:     1'b0,
				down_ok:     RST_FOLLOW[FW_DOWN_BIT],
				seq:         PSCC_OFF};
		end else begin
			st_reg <= st_next;
		end
	end

	// Register port answer
	assign cmd_rdata = st_reg.rdata;
	assign cmd_valid = st_reg.rvalid;
	assign coef_index = st_reg.coef_idx;

	// Fast transient decode
	assign outer_multiplier        = st_reg.fast[31:30];
	assign load_inner_pct_half     = st_reg.load_pct;
	assign release_inner_pct_half  = st_reg.rel_pct;
	assign load_outer_corr_time    = st_reg.fast[23:20];
	assign load_inner_corr_time    = st_reg.fast[19:16];
	assign release_outer_corr_time = st_reg.fast[15:12];
	assign release_inner_corr_time = st_reg.fast[11:8];
	assign load_blank_units        = st_reg.load_blank;
	assign release_blank_units     = st_reg.rel_blank;

	// Voltage fault outputs
	assign ov_fault      = st_reg.ov_fault;
	assign uv_fault      = st_reg.uv_fault;
	assign lowside_on_ov = st_reg.lowside;

	// Temperature outputs
	assign ext_temp_report   = st_reg.temp_report;
	assign temp_src_external = st_reg.sense_tc[TC_SRC_BIT];
	assign temp_coeff_factor = st_reg.sense_tc[6:0];

	// Non-overlap outputs, signed bytes
	assign novl_hl_ns = st_reg.hl_used;
	assign novl_lh_ns = st_reg.lh_used;

	// Sequencing output
	assign output_enable = (st_reg.seq == PSCC_ON);

	// Tracking outputs
	assign track_enable       = st_reg.follow[FW_EN_BIT];
	assign track_half         = st_reg.follow[FW_HALF_BIT];
	assign track_limit_input  = st_reg.follow[FW_LIMIT_BIT];
	assign track_down_allowed = st_reg.down_ok;
endmodule

/* verification/pscc_chk.sv */
// Port checker for the configuration command bank.
// Assumes binding into pscc_top; sees only its ports.
`timescale 1ns/1ps
module pscc_chk
	import pscc_pkg::*;
#(
	parameter int BYTE_W = 8
) (
	// Clock, reset, command port
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       cmd_read,
	input wire logic       cmd_valid,
	// Coefficient stream
	input wire logic       coef_byte_valid,
	input wire logic       coef_start,
	input wire logic [3:0] coef_index,
	// Faults and thresholds
	input wire logic [3:0] load_inner_pct_half,
	input wire logic       ov_violation,
	input wire logic       uv_violation,
	input wire logic       sample_strobe,
	input wire logic       ov_fault,
	input wire logic       uv_fault,
	input wire logic       lowside_on_ov,
	// Non-overlap, sequencing, tracking
	input wire logic [7:0] novl_hl_ns,
	input wire logic [7:0] novl_max_hl_ns,
	input wire logic       enable_request,
	input wire logic       output_enable,
	input wire logic       power_good_flag,
	input wire logic       track_down_allowed
);
	// One clock domain
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_read_answer: assert property (cmd_valid == $past(cmd_read)) else $error("late answer");
	a_coef_cap: assert property (coef_index <= 4'h8) else $error("coef index high");
	a_coef_step: assert property (coef_byte_valid && !coef_start && coef_index < 4'h8
		|=> coef_index == $past(coef_index) + 4'h1) else $error("coef index skip");
	a_inner_lvl: assert property (load_inner_pct_half inside {[4'h1:4'h8]}) else $error("lvl");
	a_ov_cause: assert property ($rose(ov_fault) |-> $past(sample_strobe && ov_violation))
		else $error("ov cause");
	a_uv_cause: assert property ($rose(uv_fault) |-> $past(sample_strobe && uv_violation))
		else $error("uv cause");
	a_lowside_fault: assert property (lowside_on_ov |-> ov_fault) else $error("lowside");
	a_novl_cap: assert property (1'b1 |=> $signed(novl_hl_ns) <= $signed($past(novl_max_hl_ns)))
		else $error("novl above max");
	a_seq_gate: assert property ($rose(output_enable) |-> $past(enable_request)) else $error("on");
	a_seq_drop: assert property (!enable_request |=> !output_enable) else $error("off");
	a_track_pg: assert property (power_good_flag |=> track_down_allowed) else $error("down");
	// Main scenarios reached
	c_read: cover property (cmd_valid);
	c_fault: cover property ($rose(ov_fault));
	c_enable: cover property ($rose(output_enable));
endmodule
bind pscc_top pscc_chk #(.BYTE_W(BYTE_W)) u_chk (.clk(clk), .reset(reset),
	.cmd_read(cmd_read), .cmd_valid(cmd_valid), .coef_byte_valid(coef_byte_valid),
	.coef_start(coef_start), .coef_index(coef_index), .load_inner_pct_half(load_inner_pct_half),
	.ov_violation(ov_violation), .uv_violation(uv_violation), .sample_strobe(sample_strobe),
	.ov_fault(ov_fault), .uv_fault(uv_fault), .lowside_on_ov(lowside_on_ov),
	.novl_hl_ns(novl_hl_ns), .novl_max_hl_ns(novl_max_hl_ns), .enable_request(enable_request),
	.output_enable(output_enable), .power_good_flag(power_good_flag),
	.track_down_allowed(track_down_allowed));

/* verification/pscc_peer.sv */
// Peer rail model broadcasting events on the inter-rail bus.
// Assumes the bench asks for one event at a time.
`timescale 1ns/1ps
module pscc_peer (
	// Clock and request
	input  wire logic       clk,
	input  wire logic       fire,
	input  wire logic       pgood,
	input  wire logic [4:0] rail,
	// Event lines
	output logic            ev_valid,
	output logic            ev_pgood,
	output logic [4:0]      ev_rail
);
	// Quiet start
	initial begin
		ev_valid = 1'b0;
		ev_pgood = 1'b0;
		ev_rail = 5'h00;
	end
	// One-cycle event; idle lines toggle so stale values mean nothing
	always @(posedge clk) begin
		ev_valid <= fire;
		ev_pgood <= fire ? pgood : ~ev_pgood;
		ev_rail <= fire ? rail : ~ev_rail;
	end
endmodule

/* verification/pscc_top_tb_top.sv */
// Self-checking bench for the configuration command bank.
// Assumes pscc_top with the checker bound and a peer rail model.
`timescale 1ns/1ps
module pscc_top_tb_top
	import pscc_pkg::*;
;
	// Design inputs, all set at time zero
	logic        clk = 1'b0, reset = 1'b1, cmd_write = 1'b0, cmd_read = 1'b0;
	logic [7:0]  cmd_code = 8'h00, coef_byte = 8'h00, adaptive_hl_ns = 8'h1E;
	logic [7:0]  adaptive_lh_ns = 8'h02;
	logic [31:0] cmd_wdata = 32'h0, cmd_rdata, d, g;
	logic        coef_byte_valid = 1'b0, coef_start = 1'b0, ov_violation = 1'b0;
	logic        uv_violation = 1'b0, sample_strobe = 1'b0, enable_request = 1'b0;
	logic        power_good_flag = 1'b0, fire = 1'b0, f_pg = 1'b0;
	logic [15:0] ext_temp_measured = 16'h0, ext_temp_report;
	logic [4:0]  f_rail = 5'h00, bus_event_rail;
	// Design outputs
	logic        cmd_valid, ov_fault, uv_fault, lowside_on_ov, temp_src_external;
	logic        bus_event_valid, bus_event_pgood, output_enable, track_enable;
	logic        track_half, track_limit_input, track_down_allowed;
	logic [3:0]  coef_index, load_inner_pct_half, release_inner_pct_half;
	logic [3:0]  load_outer_corr_time, load_inner_corr_time;
	logic [3:0]  release_outer_corr_time, release_inner_corr_time;
	logic [1:0]  outer_multiplier;
	logic [7:0]  load_blank_units, release_blank_units, novl_hl_ns, novl_lh_ns;
	logic [6:0]  temp_coeff_factor;
	// Register table, expectations and counters
	logic [7:0]  cd [10] = '{CMD_INDUCTANCE, CMD_FAST_TRANS, CMD_VFAULT, CMD_XT_SCALE,
		CMD_XT_OFFSET, CMD_SENSE_TC, CMD_NOVL_TIMES, CMD_NOVL_MODE, CMD_RAIL_ORDER, CMD_FOLLOW};
	logic [31:0] rv [10] = '{RST_INDUCTANCE, RST_FAST_TRANS, RST_VFAULT, RST_XT_SCALE,
		RST_XT_OFFSET, RST_SENSE_TC, RST_NOVL_TIMES, RST_NOVL_MODE, RST_RAIL_ORDER, RST_FOLLOW};
	logic [31:0] mk [10] = '{32'hFFFF, 32'hFFFFFFFF, 32'h8F, 32'hFFFF, 32'hFFFF, 32'hFF,
		32'hFFFF, 32'hFFFF, 32'h9F9F, 32'h87};
	logic [7:0]  bt [16] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h09, 8'h11, 8'h21, 8'h31,
		8'h41, 8'h51, 8'h61, 8'h81, 8'hA1, 8'hB1, 8'hC1, 8'hE1};
	logic [31:0] expq [$];
	int          miscompares = 0, compares = 0;
	wire [15:0]  novl = {novl_hl_ns, novl_lh_ns};
	wire [3:0]   trk = {track_enable, track_half, track_limit_input, track_down_allowed};
	// 100 MHz clock
	always #5 clk = ~clk;
	// Design with both maximum limits tied at 60 ns
	pscc_top #(.BYTE_W(8)) u_dut (.clk, .reset, .cmd_code, .cmd_write, .cmd_read, .cmd_wdata,
		.cmd_rdata, .cmd_valid, .coef_byte_valid, .coef_byte, .coef_start, .coef_index,
		.load_inner_pct_half, .release_inner_pct_half, .outer_multiplier, .load_outer_corr_time,
		.load_inner_corr_time, .release_outer_corr_time, .release_inner_corr_time,
		.load_blank_units, .release_blank_units, .ov_violation, .uv_violation, .sample_strobe,
		.ov_fault, .uv_fault, .lowside_on_ov, .ext_temp_measured, .ext_temp_report,
		.temp_src_external, .temp_coeff_factor, .adaptive_hl_ns, .adaptive_lh_ns,
		.novl_max_hl_ns(8'h3C), .novl_max_lh_ns(8'h3C), .novl_hl_ns, .novl_lh_ns,
		.enable_request, .bus_event_valid, .bus_event_pgood, .bus_event_rail, .output_enable,
		.track_enable, .track_half, .track_limit_input, .track_down_allowed, .power_good_flag);
	// Peer rails on the inter-rail bus
	pscc_peer u_peer (.clk, .fire, .pgood(f_pg), .rail(f_rail), .ev_valid(bus_event_valid),
		.ev_pgood(bus_event_pgood), .ev_rail(bus_event_rail));
	// Value compare, counted
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] v);
		compares++;
		if (v !== e) begin
			miscompares++;
			$display("mismatch %s exp %h got %h", n, e, v);
		end
	endtask
	// Edges pass; inputs move 1 ns after the last
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Command write or read, strobe for one edge; reads note their answer
	task automatic cmd(input logic w, input logic [7:0] c, input logic [31:0] v);
		tick(1);
		cmd_code = c;
		cmd_wdata = v;
		cmd_write = w;
		cmd_read = !w;
		if (!w) expq.push_back(v);
		tick(1);
		cmd_write = 1'b0;
		cmd_read = 1'b0;
	endtask
	// Peer event, then settle
	task automatic ev(input logic p, input logic [4:0] r);
		tick(1);
		fire = 1'b1;
		f_pg = p;
		f_rail = r;
		tick(1);
		fire = 1'b0;
		tick(3);
	endtask
	// One fault sample
	task automatic stb(input logic o, input logic u);
		tick(1);
		ov_violation = o;
		uv_violation = u;
		sample_strobe = 1'b1;
		tick(1);
		sample_strobe = 1'b0;
	endtask
	// Verdict and end of run
	task automatic complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Read answers against the oldest note
	always @(posedge clk) begin
		if (cmd_valid === 1'b1) begin
			if (expq.size() == 0) cmp("rdata_extra", 32'h0, 32'h1);
			else cmp("rdata", expq.pop_front(), cmd_rdata);
		end
	end
	// Hang guard
	initial begin
		tick(30000);
		miscompares++;
		complete_run;
	end
	// Main sequence
	initial begin
		void'($urandom(32'hBB125F91));
		tick(20);
		reset = 1'b0;
		for (int i = 0; i < 10; i++) cmd(0, cd[i], rv[i]);
		cmd(0, 8'hD0, 32'h0);
		for (int i = 0; i < 10; i++) begin
			d = $urandom;
			if (i == 3) d = RST_XT_SCALE;
			if (i == 7) d = d & 32'h8F8F;
			cmd(1, cd[i], d);
			cmd(0, cd[i], d & mk[i]);
		end
		$display("test registers done");
		for (int i = 0; i < 16; i++) begin
			d = $urandom;
			d[7:0] = {4'(i), 4'(15 - i)};
			cmd(1, CMD_FAST_TRANS, d);
			g = {d[31:30], {1'b0, d[29:27]} + 4'h1, {1'b0, d[26:24]} + 4'h1};
			cmp("levels", g, {outer_multiplier, load_inner_pct_half, release_inner_pct_half});
			g = {load_outer_corr_time, load_inner_corr_time,
				release_outer_corr_time, release_inner_corr_time};
			cmp("corr", d[23:8], g);
			cmp("blank", {bt[i], bt[15 - i]}, {load_blank_units, release_blank_units});
		end
		$display("test fast done");
		cmd(1, CMD_VFAULT, 32'h83);
		repeat (3) stb(1, 0);
		stb(0, 0);
		repeat (3) stb(1, 0);
		tick(2);
		cmp("ov_fault", 0, ov_fault);
		stb(1, 0);
		tick(2);
		cmp("ov_fault", 1, ov_fault);
		cmp("lowside", 1, lowside_on_ov);
		cmp("uv_fault", 0, uv_fault);
		repeat (4) stb(0, 1);
		tick(2);
		cmp("uv_fault", 1, uv_fault);
		reset = 1'b1;
		tick(3);
		reset = 1'b0;
		cmp("ov_fault", 0, ov_fault);
		cmd(1, CMD_VFAULT, 32'h00);
		stb(1, 0);
		tick(2);
		cmp("ov_fault", 1, ov_fault);
		cmp("lowside", 0, lowside_on_ov);
		$display("test fault done");
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			d[7] = i[0];
			cmd(1, CMD_XT_OFFSET, d[15:0]);
			ext_temp_measured = d[31:16];
			tick(2);
			cmp("temp", 16'(d[31:16] + d[15:0]), ext_temp_report);
			cmd(1, CMD_SENSE_TC, d[7:0]);
			cmp("tempco", d[7:0], {temp_src_external, temp_coeff_factor});
		end
		$display("test temp done");
		cmd(1, CMD_NOVL_TIMES, 32'h2819);
		tick(2);
		cmp("novl", 16'h2819, novl);
		cmd(1, CMD_NOVL_TIMES, 32'h7F05);
		tick(2);
		cmp("novl", 16'h3C0C, novl);
		cmd(0, CMD_NOVL_TIMES, 32'h7F05);
		cmd(1, CMD_NOVL_MODE, 32'h0303);
		tick(2);
		cmp("novl", 16'h1E06, novl);
		cmd(1, CMD_NOVL_MODE, 32'h8383);
		adaptive_hl_ns = 8'h2A;
		adaptive_lh_ns = 8'h2B;
		tick(3);
		cmp("novl", 16'h1E06, novl);
		$display("test novl done");
		cmd(1, CMD_RAIL_ORDER, 32'h8582);
		enable_request = 1'b1;
		ev(1, 5'h03);
		cmp("oe", 0, output_enable);
		ev(1, 5'h05);
		cmp("oe", 1, output_enable);
		ev(0, 5'h05);
		cmp("oe", 1, output_enable);
		ev(0, 5'h02);
		cmp("oe", 0, output_enable);
		enable_request = 1'b0;
		cmd(1, CMD_RAIL_ORDER, 32'h0000);
		enable_request = 1'b1;
		tick(3);
		cmp("oe", 1, output_enable);
		enable_request = 1'b0;
		$display("test seq done");
		cmd(1, CMD_FOLLOW, 32'h87);
		cmp("track", 4'hF, trk);
		cmd(1, CMD_FOLLOW, 32'h80);
		cmp("track", 4'h8, trk);
		power_good_flag = 1'b1;
		tick(1);
		cmp("track", 4'h9, trk);
		$display("test track done");
		tick(1);
		coef_start = 1'b1;
		tick(1);
		coef_start = 1'b0;
		coef_byte_valid = 1'b1;
		cmp("coef", 0, coef_index);
		for (int i = 0; i < 10; i++) begin
			coef_byte = $urandom;
			tick(1);
			cmp("coef", (i < 8) ? i + 1 : 8, coef_index);
		end
		coef_byte_valid = 1'b0;
		$display("test coef done");
		for (int i = 0; i < 10 && expq.size() > 0; i++) tick(1);
		if (expq.size() > 0) miscompares++;
		complete_run;
	end
endmodule
